// ===== logic/ecti_pkg.sv
// package: port map, field layout and timing constants of the timer and interrupt block
package ecti_pkg;
  // indexes of the sixteen ports, each an aligned apb word at four times the index
  localparam int unsigned NumPorts     = 16;
  localparam logic [3:0]  IdxLatchSrc1 = 4'h3;
  localparam logic [3:0]  IdxLatchSrc3 = 4'h5;
  localparam logic [3:0]  IdxTimeBase  = 4'h9;
  localparam logic [3:0]  IdxDivider   = 4'hA;
  localparam logic [3:0]  IdxPicCmd    = 4'hC;
  localparam logic [3:0]  IdxPicMask   = 4'hD;
  localparam logic [3:0]  IdxStatus    = 4'hE;
  localparam logic [3:0]  IdxVector    = 4'hF;
  // fields
  localparam int unsigned LatchSrcLsb  = 0;
  localparam int unsigned TimeBaseLsb  = 0;
  localparam int unsigned IntSelBit    = 3;
  localparam logic [2:0]  LatchTimer   = 3'h4;
  localparam logic [7:0]  DividerReset = 8'h01;
  // time bases in microseconds and derived cycle counts at 20 mhz
  localparam int unsigned ClkHz        = 20000000;
  localparam int unsigned MsUs         = 1000;
  localparam int unsigned MsCycles     = (MsUs * (ClkHz / 1000000));
  localparam int unsigned PulseUs      = 1;
  localparam int unsigned PulseCycles  = ((PulseUs * ClkHz + 999999) / 1000000) * 2;
  // pic command bits
  localparam int unsigned Icw1Bit      = 4;
  localparam logic [7:0]  PicMaskReset = 8'hFF;

  typedef enum logic [1:0] {
    PIC_IDLE   = 2'b00,
    PIC_ICW2   = 2'b01,
    PIC_ICW4   = 2'b10
  } ecti_pic_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [5:0]  paddr;
    logic [31:0] pwdata;
  } ecti_apb_req_t;

  typedef struct packed {
    logic [2:0] overflow;
    logic [2:0] index;
    logic       digitalInputZero;
    logic       digitalInputOne;
  } ecti_src_t;
endpackage

// ===== logic/ecti_ms_tick.sv
// millisecond tick and selectable base period divider
`timescale 1ns/10ps
module ecti_ms_tick (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // base selection 0:1ms 1:10ms 2:100ms 3:1000ms
  input  wire logic [1:0] baseSel,
  // one pulse per base period
  output logic            baseTick
);
  typedef struct packed {
    logic [14:0] msCnt;
    logic [9:0]  baseCnt;
    logic        tick;
  } ecti_tick_st_t;

  ecti_tick_st_t st;
  ecti_tick_st_t next_st;

  // base period length in milliseconds
  function automatic logic [9:0] baseLen(input logic [1:0] sel);
    case (sel)
      2'h0:    baseLen = 10'h001;
      2'h1:    baseLen = 10'h00A;
      2'h2:    baseLen = 10'h064;
      default: baseLen = 10'h3E8;
    endcase
  endfunction

  // count system clocks to a ms, then ms to a base period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.msCnt == 15'(ecti_pkg::MsCycles - 1)) begin
      next_st.msCnt = 15'h0000;
      if (st.baseCnt >= baseLen(baseSel) - 10'h001) begin
        next_st.baseCnt = 10'h000;
        next_st.tick = 1'b1;
      end else begin
        next_st.baseCnt = st.baseCnt + 10'h001;
      end
    end else begin
      next_st.msCnt = st.msCnt + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign baseTick = st.tick;

  // a tick is always one cycle wide
  tick_single_a: assert property (@(posedge sys_clk) disable iff (srst)
    baseTick |=> !baseTick) else $error("base tick longer than one cycle");
endmodule

// ===== logic/ecti_timer_irq.sv
// timer, source edge shaping and on-card interrupt controller with apb ports
//
// What this block does
// - timer period equals base period times multiplier
// - base period selectable as 1, 10, 100 or 1000 ms
// - multiplier from 1 to 255, giving 1 ms up to 255 s
// - base and multiplier come from ports nine and ten
// - a timer pulse may latch counters and independently raise an interrupt
// - a channel latches on the timer only if its source port selects it
// - nine conditions: three overflows, three indexes, two inputs, timer
// - conditions enter an eight-input controller driving one host line
// - bit three of port nine picks input one or timer for shared input
// - controller registers reached through ports twelve and thirteen
// - the first acknowledge is made on the card without host action
// - reading port fifteen is the second acknowledge and returns the vector
// - sixteen consecutive ports, each an offset from the base
// - timer-source channels latch on each rising timer pulse
// - latch source taken from bits zero to two of its port
`timescale 1ns/10ps
module ecti_timer_irq (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // apb slave
  input  wire ecti_pkg::ecti_apb_req_t apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // interrupt conditions from pins and counter logic
  input  wire ecti_pkg::ecti_src_t   srcIn,
  // counter latch strobes and host interrupt
  output logic [2:0]                 timerLatch,
  output logic                       hostIrq
);
  typedef struct packed {
    logic [2:0][2:0]       srcSync0;
    logic [7:0]            pinSync0;
    logic [7:0]            pinSync1;
    logic [7:0]            pinSync2;
    logic [7:0]            pinLevel;
    logic [2:0][2:0]       latchSrc;
    logic [3:0]            timeBase;
    logic [7:0]            divider;
    logic [7:0]            divCnt;
    logic [5:0]            pulseCnt;
    logic [7:0]            lineLast;
    logic [7:0]            irr;
    logic [7:0]            isr;
    logic [7:0]            imr;
    logic [4:0]            vecBase;
    ecti_pkg::ecti_pic_st_t picSt;
    logic [2:0]            latchOut;
    logic                  irq;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  err;
  } ecti_state_t;

  ecti_state_t st;
  ecti_state_t next_st;
  logic        baseTick;
  logic        timerLine;
  logic [7:0]  picLines;
  logic [7:0]  pending;
  logic [2:0]  topIdx;
  logic        access;
  logic [3:0]  portIdx;

  ecti_ms_tick u_tick (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .baseSel  (st.timeBase[1:0]),
    .baseTick (baseTick)
  );

  // lowest set bit wins priority
  function automatic logic [2:0] prioIdx(input logic [7:0] req);
    prioIdx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        prioIdx = 3'(i);
      end
    end
  endfunction

  // port decode, word aligned: sixteen ports only
  assign access  = apbReq.psel && apbReq.penable;
  assign portIdx = apbReq.paddr[5:2];
  assign timerLine = (st.pulseCnt != 6'h00);
  // shared input seven: digital input one or timer
  assign picLines = {st.timeBase[ecti_pkg::IntSelBit] ? timerLine : st.pinLevel[7],
                     st.pinLevel[6:0]};
  assign pending  = st.irr & ~st.imr;
  assign topIdx   = prioIdx(pending);

  always_comb begin
    next_st = st;
    next_st.ready = 1'b0;
    next_st.err = 1'b0;
    next_st.latchOut = 3'h0;
    // three-stage sync of pins; change counts when stages two and three agree
    next_st.pinSync0 = {srcIn.digitalInputOne, srcIn.digitalInputZero, srcIn.index,
                        srcIn.overflow};
    next_st.pinSync1 = st.pinSync0;
    next_st.pinSync2 = st.pinSync1;
    for (int b = 0; b < 8; b++) begin
      if (st.pinSync1[b] == st.pinSync2[b]) begin
        next_st.pinLevel[b] = st.pinSync2[b];
      end
    end
    // multiplier count, restarted after each pulse
    if (baseTick) begin
      if (st.divCnt >= st.divider - 8'h01 || st.divider == 8'h00) begin
        next_st.divCnt = 8'h00;
        next_st.pulseCnt = 6'(ecti_pkg::PulseCycles);
        for (int c = 0; c < 3; c++) begin
          next_st.latchOut[c] = (st.latchSrc[c] == ecti_pkg::LatchTimer);
        end
      end else begin
        next_st.divCnt = st.divCnt + 8'h01;
      end
    end else if (st.pulseCnt != 6'h00) begin
      next_st.pulseCnt = st.pulseCnt - 6'h01;
    end
    // edge-triggered request capture
    next_st.lineLast = picLines;
    next_st.irr = st.irr | (picLines & ~st.lineLast);
    next_st.irq = (pending != 8'h00) && (st.isr == 8'h00);
    // apb access
    if (access && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.rdata = 32'h0000_0000;
      if (apbReq.pwrite) begin
        case (portIdx)
          4'h3, 4'h4, 4'h5: next_st.latchSrc[portIdx - ecti_pkg::IdxLatchSrc1] =
                              apbReq.pwdata[ecti_pkg::LatchSrcLsb +: 3];
          ecti_pkg::IdxTimeBase: next_st.timeBase = apbReq.pwdata[3:0];
          ecti_pkg::IdxDivider: next_st.divider = apbReq.pwdata[7:0];
          ecti_pkg::IdxPicCmd: begin
            if (apbReq.pwdata[ecti_pkg::Icw1Bit]) begin
              next_st.picSt = ecti_pkg::PIC_ICW2;
              next_st.imr = 8'h00;
              // an edge in the init cycle still sets its request
              next_st.irr = picLines & ~st.lineLast;
              next_st.isr = 8'h00;
            end else begin
              next_st.isr = 8'h00; // end of interrupt
            end
          end
          ecti_pkg::IdxPicMask: begin
            case (st.picSt)
              ecti_pkg::PIC_ICW2: begin
                next_st.vecBase = apbReq.pwdata[7:3];
                next_st.picSt = ecti_pkg::PIC_ICW4;
              end
              ecti_pkg::PIC_ICW4: next_st.picSt = ecti_pkg::PIC_IDLE;
              default: next_st.imr = apbReq.pwdata[7:0];
            endcase
          end
          default: next_st.err = (portIdx > ecti_pkg::IdxPicMask);
        endcase
      end else begin
        case (portIdx)
          ecti_pkg::IdxPicCmd: next_st.rdata = {24'h00_0000, st.irr};
          ecti_pkg::IdxPicMask: next_st.rdata = {24'h00_0000, st.imr};
          ecti_pkg::IdxStatus: next_st.rdata = {27'h000_0000, st.pinLevel[7:6],
                                                 st.pinLevel[5:3]};
          ecti_pkg::IdxVector: begin
            // first acknowledge was internal; this read is the second
            next_st.rdata = {24'h00_0000, st.vecBase, topIdx};
            if (pending != 8'h00) begin
              next_st.isr[topIdx] = 1'b1;
              next_st.irr[topIdx] = picLines[topIdx] & ~st.lineLast[topIdx];
            end
          end
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.imr <= ecti_pkg::PicMaskReset;
      st.divider <= ecti_pkg::DividerReset;
    end else begin
      st <= next_st;
    end
  end

  assign prdata     = st.rdata;
  assign pready     = st.ready;
  assign pslverr    = st.err;
  assign timerLatch = st.latchOut;
  assign hostIrq    = st.irq;

  // timer pulse latches channel 0 on the same cycle if its source port selects the timer
  latch_on_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(timerLine) |-> timerLatch[0] == ($past(st.latchSrc[0]) == ecti_pkg::LatchTimer))
    else $error("latch missed");
  latch_source_a: assert property (@(posedge sys_clk) disable iff (srst)
    timerLatch[1] |-> st.latchSrc[1] == ecti_pkg::LatchTimer) else $error("bad latch");
  pulse_width_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(timerLine) |-> timerLine [*8]) else $error("pulse too short");
  edge_capture_a: assert property (@(posedge sys_clk) disable iff (srst)
    (picLines[0] && !st.lineLast[0]) |=> st.irr[0]) else $error("edge lost");
  irq_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    (pending != 8'h00 && st.isr == 8'h00) |=> hostIrq) else $error("irq missing");
  vector_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (access && !st.ready && !apbReq.pwrite && portIdx == ecti_pkg::IdxVector)
      |=> pready && prdata[7:3] == st.vecBase) else $error("bad vector");
  apb_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
    (access && !pready) |=> pready) else $error("no answer");
  shared_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    !st.timeBase[ecti_pkg::IntSelBit] |-> picLines[7] == st.pinLevel[7])
    else $error("shared input");
endmodule

// ===== tb/ecti_host_model.sv
// host model: apb master that sets up and acknowledges the controller
`timescale 1ns/10ps
module ecti_host_model (
  // clock
  input  wire logic               sys_clk,
  // apb request and answer
  output ecti_pkg::ecti_apb_req_t apbReq,
  input  wire logic [31:0]        prdata,
  input  wire logic               pready,
  input  wire logic               pslverr
);
  logic [31:0] rdata;
  logic        slverr;

  // bus idle from time zero
  initial apbReq = '0;

  // one transfer, request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] port, input logic [7:0] wd);
    @(posedge sys_clk);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= {port, 2'b00};
    apbReq.pwdata  <= {24'h00_0000, wd};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    slverr = pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  // init word, vector base, then mode word
  task automatic picInit();
    xfer(1'b1, ecti_pkg::IdxPicCmd, 8'h13);
    xfer(1'b1, ecti_pkg::IdxPicMask, 8'h40);
    xfer(1'b1, ecti_pkg::IdxPicMask, 8'h01);
  endtask

  // second acknowledge fetches the vector
  task automatic ack();
    xfer(1'b0, ecti_pkg::IdxVector, 8'h00);
  endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the timer and interrupt block
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] mask;
    logic       irq;
    logic [7:0] vec;
  } ecti_row_t;

  logic                    sys_clk;
  logic                    srst;
  ecti_pkg::ecti_apb_req_t apbReq;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [7:0]              src8;
  ecti_pkg::ecti_src_t     srcIn;
  logic [2:0]              timerLatch;
  logic                    hostIrq;
  int                      badCount;
  int                      nTests;
  longint                  t0;
  ecti_row_t               rows [9];

  // controller input k is bit k of src8
  assign srcIn = {src8[2:0], src8[5:3], src8[6], src8[7]};

  ecti_timer_irq ecti_timer_irq_inst (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .apbReq     (apbReq),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .srcIn      (srcIn),
    .timerLatch (timerLatch),
    .hostIrq    (hostIrq)
  );

  ecti_host_model ecti_host_model_inst (
    .sys_clk (sys_clk),
    .apbReq  (apbReq),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // 20 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    ecti_host_model_inst.xfer(1'b1, p, d);
  endtask

  task automatic rd(input logic [3:0] p, input logic [31:0] exp);
    ecti_host_model_inst.xfer(1'b0, p, 8'h00);
    check(ecti_host_model_inst.rdata, exp);
  endtask

  // bounded waits on the host line and the latch strobes
  task automatic waitIrq(input logic lvl, input int lim);
    for (int n = 0; n < lim && hostIrq !== lvl; n++) begin
      @(posedge sys_clk);
    end
  endtask

  task automatic waitLatch();
    for (int n = 0; n < 50000 && timerLatch === 3'b000; n++) begin
      @(posedge sys_clk);
    end
  endtask

  // hang guard
  initial begin
    repeat (95000) @(posedge sys_clk);
    badCount++;
    finalReport();
  end

  initial begin
    rows = '{'{8'h01, 8'hFE, 1'b1, 8'h40}, '{8'h02, 8'hFD, 1'b1, 8'h41},
             '{8'h04, 8'hFB, 1'b1, 8'h42}, '{8'h08, 8'hF7, 1'b1, 8'h43},
             '{8'h10, 8'hEF, 1'b1, 8'h44}, '{8'h20, 8'hDF, 1'b1, 8'h45},
             '{8'h40, 8'hBF, 1'b1, 8'h46}, '{8'h80, 8'h7F, 1'b1, 8'h47},
             '{8'h01, 8'hFF, 1'b0, 8'h00}};
    srst = 1'b1;
    src8 = 8'h00;
    badCount = 0;
    nTests = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check(hostIrq, 1'b0);
    rd(ecti_pkg::IdxPicMask, 32'h0000_00FF);
    // status port shows index and digital inputs
    src8 <= 8'hA8;
    repeat (10) @(posedge sys_clk);
    rd(ecti_pkg::IdxStatus, 32'h0000_0015);
    src8 <= 8'h00;
    wr(ecti_pkg::IdxStatus, 8'h00);
    check(ecti_host_model_inst.slverr, 1'b1);
    rd(4'hB, 32'h0000_0000);
    ecti_host_model_inst.picInit();
    // one source unmasked per row, last row masked
    foreach (rows[i]) begin
      wr(ecti_pkg::IdxPicMask, rows[i].mask);
      src8 <= rows[i].src;
      repeat (40) @(posedge sys_clk);
      src8 <= 8'h00;
      waitIrq(rows[i].irq, 20);
      check(hostIrq, rows[i].irq);
      if (rows[i].irq) begin
        ecti_host_model_inst.ack();
        check(ecti_host_model_inst.rdata, {24'h00_0000, rows[i].vec});
        waitIrq(1'b0, 4);
        check(hostIrq, 1'b0);
        wr(ecti_pkg::IdxPicCmd, 8'h20);
      end
    end
    rd(ecti_pkg::IdxPicCmd, 32'h0000_0001);
    // timer: 1 ms base, multiplier 2, on input 7, channels 1 and 3 latch
    wr(ecti_pkg::IdxLatchSrc1, 8'h04);
    wr(ecti_pkg::IdxLatchSrc1 + 4'h1, 8'h03);
    wr(ecti_pkg::IdxLatchSrc3, 8'h0C);
    wr(ecti_pkg::IdxDivider, 8'h02);
    wr(ecti_pkg::IdxTimeBase, 8'h08);
    wr(ecti_pkg::IdxPicMask, 8'h7F);
    waitLatch();
    t0 = $time;
    check(timerLatch, 3'b101);
    waitIrq(1'b1, 60);
    check(hostIrq, 1'b1);
    rd(ecti_pkg::IdxVector, 32'h0000_0047);
    wr(ecti_pkg::IdxPicCmd, 8'h20);
    waitLatch();
    check(($time - t0) / 50, 2 * ecti_pkg::MsCycles);
    finalReport();
  end
endmodule
